// ==== dsa_sequencer.sv ====
// Dual-slope converter sequencer, digit multiplexer and result buffer
`timescale 1ns/1ps
module dsa_sequencer
  import dsa_pkg::*;
#(
  parameter int CNT_W = CNT_WIDTH,  // Counter width
  parameter int DEPTH = BUF_DEPTH   // Result buffer depth
) (
  input  wire logic             sys_clk,       // System clock, 10 MHz
  input  wire logic             rst,           // Synchronous reset, active high
  input  wire logic             clkEn,         // Freezes all state while low
  input  wire logic             compIn,        // Comparator: integrator past threshold
  output logic                  integShort,    // Integrator shorted, offset charge
  output logic                  integInput,    // Integrate unknown input
  output logic                  integRef,      // Integrate reference
  output logic                  inputInvert,   // Input switch set for negative
  output logic                  refInvert,     // Reference switch set for negative
  output logic                  endOfConv,     // End-of-conversion pulse
  output logic                  overrangeN,    // Low while reading is overrange
  output logic                  digitStrobe1,  // Leading half digit select
  output logic                  digitStrobe2,  // Hundreds digit select
  output logic                  digitStrobe3,  // Tens digit select
  output logic                  digitStrobe4,  // Trailing digit select
  output logic                  digitBit0,     // Digit data bit 0
  output logic                  digitBit1,     // Digit data bit 1
  output logic                  digitBit2,     // Digit data bit 2
  output logic                  digitBit3,     // Digit data bit 3
  output logic                  resultValid,   // Buffered result available
  input  wire logic             resultReady,   // Receiver takes the result
  output logic [CNT_W-1:0]      resultCount,   // Buffered result count
  output logic                  resultNeg      // Buffered result polarity
);

  localparam int SLOT_CYC = MUX_DIV / DIGIT_COUNT;
  localparam int FILL_W   = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CHG_LAST = CNT_W'(CHARGE_CYC - 1);
  localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(OFFSET_MAX_CYC - 1);
  localparam logic [CNT_W-1:0] UP_LAST  = CNT_W'(UP_CYC - 1);
  localparam logic [CNT_W-1:0] EXT_LAST = CNT_W'(EXTEND_CYC - 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FULL_SCALE);
  localparam logic [CNT_W-1:0] UNDER_CNT = CNT_W'(UNDER_LIMIT);
  localparam logic [CNT_W-1:0] LEAD_CNT = CNT_W'(LEAD_WEIGHT);
  localparam logic [CNT_W-1:0] TEN      = CNT_W'(DEC_BASE);
  localparam logic [CNT_W-1:0] HUNDRED  = CNT_W'(DEC_BASE * DEC_BASE);
  localparam logic [6:0] SCAN_LAST = 7'(MUX_DIV - 1);
  localparam logic [6:0] SCAN_EOC  = 7'(BLANK_CYC - 1);
  localparam logic [6:0] SLOT_LEN  = 7'(SLOT_CYC);
  localparam logic [6:0] BLANK_LEN = 7'(BLANK_CYC);
  localparam logic [FILL_W-1:0] FILL_MAX = FILL_W'(DEPTH);

  typedef struct packed {
    dsa_seg_t                    seg;        // Current segment
    logic [CNT_W-1:0]            segCnt;     // Clocks spent in segment
    logic [CNT_W-1:0]            offsetCnt;  // Latched comparator offset count
    logic [CNT_W-1:0]            resCnt;     // Result count being built
    logic                        tripped;    // Comparator crossed in segment six
    logic                        negLast;    // Polarity of previous conversion
    logic                        negNow;     // Polarity of this conversion
    logic                        compMeta;   // Synchroniser stage one
    logic                        compSync;   // Synchroniser stage two
    logic [CNT_W-1:0]            dispCount;  // Reading on display
    logic                        dispNeg;    // Polarity on display
    logic [6:0]                  scanCnt;    // Position in digit scan
    logic [3:0]                  digit;      // Digit data
    logic                        eoc;        // Conversion finished this clock
    logic [DEPTH-1:0][CNT_W:0]   bufWord;    // Buffer entries, polarity on top
    logic [FILL_W-1:0]           bufFill;    // Buffer occupancy
  } dsa_state_t;

  dsa_state_t r;
  dsa_state_t next_r;
  logic [3:0] strobeVec;
  logic [CNT_W-1:0] clampCnt;
  logic overRange;
  logic underRange;
  logic leadOne;

  // Reading classification for the leading digit code
  always_comb begin
    overRange  = r.dispCount > FULL_CNT;
    underRange = r.dispCount < UNDER_CNT;
    clampCnt   = overRange ? FULL_CNT : r.dispCount;
    leadOne    = clampCnt >= LEAD_CNT;
  end

  // Next-state logic for sequencer, buffer and multiplexer
  always_comb begin
    logic [CNT_W-1:0] low3;
    logic [6:0]       slot;
    next_r = r;
    low3   = '0;
    slot   = '0;
    next_r.compMeta = compIn;
    next_r.compSync = r.compMeta;
    next_r.eoc      = 1'b0;
    // Drain one entry when the receiver takes it
    if (resultReady && r.bufFill != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_r.bufWord[i] = r.bufWord[i + 1];
      end
      next_r.bufFill = r.bufFill - 1'b1;
    end
    next_r.segCnt = r.segCnt + 1'b1;
    unique case (r.seg)
      SEG_CHARGE1, SEG_CHARGE2: begin
        if (r.segCnt == CHG_LAST) begin
          next_r.seg    = (r.seg == SEG_CHARGE1) ? SEG_OFFSET : SEG_UP;
          next_r.segCnt = '0;
        end
      end
      SEG_OFFSET: begin
        if (r.compSync || r.segCnt == OFF_LAST) begin
          next_r.offsetCnt = r.segCnt;
          next_r.seg       = SEG_CHARGE2;
          next_r.segCnt    = '0;
        end
      end
      SEG_UP: begin
        if (r.segCnt == UP_LAST) begin
          next_r.negNow  = r.negLast ^ ~r.compSync;
          next_r.seg     = SEG_DOWN;
          next_r.segCnt  = '0;
          next_r.resCnt  = '0;
          next_r.tripped = 1'b0;
        end
      end
      SEG_DOWN: begin
        if ({1'b0, r.segCnt} + 1'b1 >= {1'b0, r.offsetCnt}) begin
          next_r.seg    = SEG_EXTEND;
          next_r.segCnt = '0;
        end
      end
      SEG_EXTEND: begin
        if (!r.tripped) begin
          if (!r.compSync) next_r.tripped = 1'b1;
          else next_r.resCnt = r.resCnt + 1'b1;
        end
        if (r.segCnt == EXT_LAST) begin
          next_r.seg    = SEG_PUSH;
          next_r.segCnt = '0;
        end
      end
      default: begin
        // Illegal segment code falls back to a fresh conversion
        next_r.seg    = SEG_CHARGE1;
        next_r.segCnt = '0;
      end
      SEG_PUSH: begin
        next_r.segCnt = r.segCnt;
        if (next_r.bufFill < FILL_MAX) begin
          next_r.bufWord[next_r.bufFill[FILL_W-2:0]] = {r.negNow, r.resCnt};
          next_r.bufFill   = next_r.bufFill + 1'b1;
          next_r.dispCount = r.resCnt;
          next_r.dispNeg   = r.negNow;
          next_r.negLast   = r.negNow;
          next_r.eoc       = 1'b1;
          next_r.seg       = SEG_CHARGE1;
          next_r.segCnt    = '0;
        end
      end
    endcase
    // Scan restarts so the leading strobe follows end of conversion
    if (next_r.eoc) next_r.scanCnt = SCAN_EOC;
    else if (r.scanCnt == SCAN_LAST) next_r.scanCnt = '0;
    else next_r.scanCnt = r.scanCnt + 1'b1;
    // Digit data for the slot that the next scan position selects
    slot = next_r.scanCnt / SLOT_LEN;
    if (slot == 7'd0) begin
      next_r.digit[3] = ~leadOne;
      next_r.digit[2] = ~r.dispNeg;
      next_r.digit[0] = overRange | underRange;
      next_r.digit[1] = ~leadOne | overRange | underRange;
    end else begin
      low3 = leadOne ? clampCnt - LEAD_CNT : clampCnt;
      if (slot == 7'd1) next_r.digit = 4'(low3 / HUNDRED);
      else if (slot == 7'd2) next_r.digit = 4'((low3 % HUNDRED) / TEN);
      else next_r.digit = 4'(low3 % TEN);
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  // One strobe per digit, dark during the blanking clocks
  genvar g;
  generate
    for (g = 0; g < DIGIT_COUNT; g++) begin : g_strobe
      assign strobeVec[g] = (r.scanCnt / SLOT_LEN == 7'(g))
                          && (r.scanCnt % SLOT_LEN >= BLANK_LEN);
    end
  endgenerate

  // Output assignments
  assign digitStrobe1 = strobeVec[0];
  assign digitStrobe2 = strobeVec[1];
  assign digitStrobe3 = strobeVec[2];
  assign digitStrobe4 = strobeVec[3];
  assign digitBit0    = r.digit[0];
  assign digitBit1    = r.digit[1];
  assign digitBit2    = r.digit[2];
  assign digitBit3    = r.digit[3];
  assign endOfConv    = r.eoc & sys_clk;
  assign overrangeN   = ~overRange;
  assign integShort   = (r.seg == SEG_CHARGE1) || (r.seg == SEG_CHARGE2);
  assign integInput   = (r.seg == SEG_UP);
  assign integRef     = (r.seg == SEG_DOWN) || (r.seg == SEG_EXTEND);
  assign inputInvert  = r.negLast;
  assign refInvert    = r.negNow;
  assign resultValid  = (r.bufFill != '0);
  assign resultCount  = r.bufWord[0][CNT_W-1:0];
  assign resultNeg    = r.bufWord[0][CNT_W];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !clkEn);

  sequence s_chargeEnd;
    r.seg == SEG_CHARGE1 && r.segCnt == CHG_LAST;
  endsequence
  sequence s_offsetDone;
    r.seg == SEG_OFFSET && (r.compSync || r.segCnt == OFF_LAST);
  endsequence

  property p_seg1Len;
    s_chargeEnd |=> r.seg == SEG_OFFSET && r.segCnt == '0;
  endproperty
  a_seg1Len: assert property (p_seg1Len) else $error("charge segment length wrong");
  property p_chargeBound;
    integShort |-> r.segCnt <= CHG_LAST;
  endproperty
  a_chargeBound: assert property (p_chargeBound) else $error("charge overran");
  property p_offsetLatch;
    s_offsetDone |=> r.seg == SEG_CHARGE2 && r.offsetCnt == $past(r.segCnt)
                     && r.offsetCnt <= OFF_LAST;
  endproperty
  a_offsetLatch: assert property (p_offsetLatch) else $error("offset not latched");
  property p_order;
    r.seg == SEG_UP && r.segCnt == UP_LAST |=> r.seg == SEG_DOWN ##1 r.seg == SEG_DOWN
                                            || r.seg == SEG_EXTEND;
  endproperty
  a_order: assert property (p_order) else $error("segment order broken");
  property p_downLen;
    r.seg == SEG_DOWN && r.offsetCnt != '0 && r.segCnt == r.offsetCnt - 1'b1
      |=> r.seg == SEG_EXTEND && r.segCnt == '0;
  endproperty
  a_downLen: assert property (p_downLen) else $error("down ramp length wrong");
  property p_downHold;
    r.seg == SEG_DOWN && ({1'b0, r.segCnt} + 1'b1 < {1'b0, r.offsetCnt})
      |=> r.seg == SEG_DOWN;
  endproperty
  a_downHold: assert property (p_downHold) else $error("down ramp ended early");
  property p_extendLen;
    r.seg == SEG_EXTEND && r.segCnt == EXT_LAST |=> r.seg == SEG_PUSH;
  endproperty
  a_extendLen: assert property (p_extendLen) else $error("extension length wrong");
  property p_overCode;
    digitStrobe1 && overRange |-> !digitBit3 && digitBit0 && !overrangeN;
  endproperty
  a_overCode: assert property (p_overCode) else $error("overrange code wrong");
  property p_underCode;
    digitStrobe1 && underRange |-> digitBit3 && digitBit0 && digitBit1;
  endproperty
  a_underCode: assert property (p_underCode) else $error("underrange code wrong");
  property p_polarity;
    digitStrobe1 |-> digitBit2 == !r.dispNeg && digitBit3 == !leadOne;
  endproperty
  a_polarity: assert property (p_polarity) else $error("half digit code wrong");
  property p_eocStrobe;
    r.eoc |=> digitStrobe1 && !r.eoc;
  endproperty
  a_eocStrobe: assert property (p_eocStrobe) else $error("leading strobe late");
  // A new conversion restarts the scan, so the gap check stands down then
  property p_blank;
    disable iff (rst || !clkEn || r.eoc)
    $fell(digitStrobe1) |-> !(|strobeVec) ##1 !(|strobeVec) ##1 digitStrobe2;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking gap wrong");
  property p_scan;
    r.scanCnt <= SCAN_LAST && $onehot0(strobeVec);
  endproperty
  a_scan: assert property (p_scan) else $error("scan out of bounds");

endmodule // dsa_sequencer

// ==== dsa_pkg.sv ====
// Constants and types shared by the dual-slope converter sequencer
package dsa_pkg;
  localparam int CHARGE_CYC     = 4000; // Offset charge segments, clock periods
  localparam int OFFSET_MAX_CYC = 800;  // Upper bound of comparator offset count
  localparam int UP_CYC         = 2000; // Input up-ramp length, one count per clock
  localparam int EXTEND_CYC     = 4000; // Down-ramp extension, clock periods
  localparam int FULL_SCALE     = 1999; // Largest in-range reading
  localparam int UNDER_LIMIT    = 180;  // Readings below this are underrange
  localparam int LEAD_WEIGHT    = 1000; // Weight of the leading half digit
  localparam int DEC_BASE       = 10;   // Decimal radix for digit extraction
  localparam int MUX_DIV        = 80;   // Clocks per full digit scan
  localparam int DIGIT_COUNT    = 4;    // Leading half digit plus three full digits
  localparam int BLANK_CYC      = 2;    // Dark clocks between digit strobes
  localparam int BUF_DEPTH      = 2;    // Result buffer entries
  localparam int CNT_WIDTH      = 12;   // Width of segment and result counters

  // Conversion segments plus the hand-off to the result buffer
  typedef enum logic [2:0] {
    SEG_CHARGE1, SEG_OFFSET, SEG_CHARGE2, SEG_UP, SEG_DOWN, SEG_EXTEND, SEG_PUSH
  } dsa_seg_t;
endpackage

// ==== dsa_receiver.sv ====
// Receiver model: takes buffered results and latches the digit data
`timescale 1ns/1ps
module dsa_receiver
  import dsa_pkg::*;
(
  input  wire logic                      sys_clk,     // System clock
  input  wire logic                      hold,        // Stall request from the bench
  input  wire logic                      resultValid, // Result offered
  input  wire logic [CNT_WIDTH-1:0]      resultCount, // Offered count
  input  wire logic                      resultNeg,   // Offered polarity
  input  wire logic [3:0]                strobe,      // Digit strobes, leading first
  input  wire logic [3:0]                code,        // Digit data
  output logic                           resultReady, // Takes the head result
  output logic [3:0][3:0]                dig,         // Last code seen per strobe
  output logic                           blank,       // Leading digit shown dark
  output logic [3:0][CNT_WIDTH:0]        pops,        // Taken words, polarity on top
  output int                             nPop         // Words taken so far
);
  int popCnt = 0;
  // Count of taken words, one driver
  assign nPop = popCnt;
  // Ready drops only while the bench asks for a stall
  assign resultReady = !hold;
  // Decoder shows nothing for codes 1010 to 1111
  assign blank = dig[0] >= 4'hA;
  // Latch each digit under its strobe and keep taken words in order
  always @(posedge sys_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (strobe[k]) dig[k] <= code;
    end
    if (resultValid && resultReady) begin
      pops[popCnt[1:0]] <= {resultNeg, resultCount};
      popCnt            <= popCnt + 1;
    end
  end
endmodule // dsa_receiver

// ==== dual_slope_adc_sequencer_tb.sv ====
// Self-checking bench for the dual-slope converter sequencer
`timescale 1ns/1ps
module dual_slope_adc_sequencer_tb;
  import dsa_pkg::*;
  logic sys_clk = 0, rst = 1, clkEn = 1, compIn = 0, hold = 1;
  logic integShort, integInput, integRef, inputInvert, refInvert;
  logic endOfConv, overrangeN, resultValid, resultReady, resultNeg, blank;
  logic [3:0]                strobe, code;
  logic [CNT_WIDTH-1:0]      resultCount;
  logic [3:0][3:0]           dig;
  logic [3:0][CNT_WIDTH:0]   pops;
  int nPop, n_mismatch = 0, tests_run = 0;
  int tgt = 0, upHi = 1, c2 = 0, rc = 0, off = 0;

  dsa_sequencer dsa_sequencer_inst (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .compIn(compIn), .integShort(integShort), .integInput(integInput),
    .integRef(integRef), .inputInvert(inputInvert), .refInvert(refInvert),
    .endOfConv(endOfConv), .overrangeN(overrangeN), .digitStrobe1(strobe[0]),
    .digitStrobe2(strobe[1]), .digitStrobe3(strobe[2]), .digitStrobe4(strobe[3]),
    .digitBit0(code[0]), .digitBit1(code[1]), .digitBit2(code[2]), .digitBit3(code[3]),
    .resultValid(resultValid), .resultReady(resultReady),
    .resultCount(resultCount), .resultNeg(resultNeg));
  dsa_receiver dsa_receiver_inst (.sys_clk(sys_clk), .hold(hold),
    .resultValid(resultValid), .resultCount(resultCount), .resultNeg(resultNeg),
    .strobe(strobe), .code(code), .resultReady(resultReady), .dig(dig),
    .blank(blank), .pops(pops), .nPop(nPop));

  // Clock of 100 ns period
  initial forever #50 sys_clk = ~sys_clk;

  // Comparator stand-in: trips the offset count, sets polarity, ends the ramp
  always @(posedge sys_clk) begin
    c2 <= integShort ? 0 : c2 + 1;
    rc <= integRef ? rc + 1 : 0;
    if (integInput) compIn <= upHi[0];
    else if (integRef) compIn <= rc < off + tgt;
    else compIn <= !integShort && c2 >= 100;
  end

  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // Count clocks while a level holds, with a bound on the wait
  task automatic run_len(ref logic s, input logic v, output int n);
    n = 0;
    while (s === v && n < 20000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 20000) begin
      n_mismatch++;
      summarize();
    end
  endtask

  // Word near a target count with a given polarity, allowing sync slack
  function automatic logic near(input logic [CNT_WIDTH:0] w, input int t, input logic ng);
    return w[CNT_WIDTH] === ng && w[CNT_WIDTH-1:0] + 4 >= t && w[CNT_WIDTH-1:0] <= t + 4;
  endfunction

  // One conversion: segment lengths, order and switch polarity
  task automatic conv(input int t, input int up, input logic invIn, input logic neg);
    int n;
    tgt = t;
    upHi = up;
    run_len(integShort, 0, n);
    chk(n < 2, 1);
    run_len(integShort, 1, n);
    chk(n, CHARGE_CYC);
    run_len(integShort, 0, n);
    chk(n < OFFSET_MAX_CYC, 1);
    off = n - 1; // Latched offset count is one below the segment length
    run_len(integShort, 1, n);
    chk(n, CHARGE_CYC);
    chk({integInput, inputInvert}, {1'b1, invIn});
    run_len(integInput, 1, n);
    chk(n, UP_CYC);
    chk({integRef, refInvert}, {1'b1, neg});
    run_len(integRef, 1, n);
    chk(n, off + EXTEND_CYC);
  endtask

  // End-of-conversion pulse, one full digit scan and the codes shown
  task automatic disp(input logic [3:0] c1, input logic [3:0] d2, input logic [3:0] d3,
                      input logic ovN);
    int n;
    int cnt [5];
    run_len(endOfConv, 0, n);
    @(negedge sys_clk);
    #1;
    chk(endOfConv, 0);
    @(posedge sys_clk);
    #1;
    chk({endOfConv, strobe}, 5'h01);
    for (int i = 0; i < 80; i++) begin
      chk($countones(strobe) <= 1, 1);
      if (i % 20 == 0) chk(strobe, 4'h1 << (i / 20));
      chk(overrangeN, ovN);
      cnt[strobe == 0 ? 4 : $clog2(strobe)]++;
      @(posedge sys_clk);
      #1;
    end
    chk(strobe, 4'h1);
    for (int k = 0; k < 4; k++) chk(cnt[k], MUX_DIV / DIGIT_COUNT - BLANK_CYC);
    chk(cnt[4], DIGIT_COUNT * BLANK_CYC);
    chk({dig[0], dig[1], dig[2]}, {c1, d2, d3});
    chk(blank, c1 >= 4'hA);
  endtask

  // Clock enable low freezes all state; a mid-run reset restarts segment one
  task automatic freeze_rst_chk();
    logic [12:0] snap;
    int n;
    @(posedge sys_clk) clkEn <= 1'b0;
    #1;
    snap = {strobe, code, integShort, integInput, integRef, resultValid, overrangeN};
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      #1;
      chk({strobe, code, integShort, integInput, integRef, resultValid, overrangeN}, snap);
    end
    @(posedge sys_clk);
    clkEn <= 1'b1;
    rst   <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk({integShort, resultValid, strobe, code, overrangeN}, 11'h401);
    @(posedge sys_clk) rst <= 1'b0;
    run_len(integShort, 1, n);
    chk(n, CHARGE_CYC);
  endtask

  // Full buffer holds the converter still without losing a word
  task automatic stall_chk();
    for (int i = 0; i < 50; i++) begin
      chk({integShort, integInput, integRef, resultValid, nPop[1:0]}, 6'h04);
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk) hold <= 1'b0;
  endtask

  // Main sequence: positive, overrange negative, then underrange under stall
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    conv(1235, 1, 0, 0);
    fork
      disp(4'h4, 4'h2, 4'h3, 1'b1);
      conv(2500, 0, 0, 1);
    join
    fork
      disp(4'h3, 4'h9, 4'h9, 1'b0);
      conv(55, 1, 1, 1);
    join
    stall_chk();
    disp(4'hB, 4'h0, 4'h5, 1'b1);
    chk(nPop, 3);
    chk(near(pops[0], 1235, 0), 1);
    chk(near(pops[1], 2500, 1), 1);
    chk(near(pops[2], 55, 1), 1);
    freeze_rst_chk();
    summarize();
  end
endmodule // dual_slope_adc_sequencer_tb
